// >>> core/fllcm_defines.vh
// Register offsets, field positions, mode codes and timing counts of the clock-loss monitor
`ifndef FLLCM_DEFINES_VH
`define FLLCM_DEFINES_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FLLCM_ADDR_CTRL1      2'h0
`define FLLCM_ADDR_CTRL2      2'h1
`define FLLCM_ADDR_STAT1      2'h2
`define FLLCM_ADDR_STAT2      2'h3
// ---------------------------------------------------------------
// Control 1 fields
// ---------------------------------------------------------------
`define FLLCM_C1_SEL_HI       5
`define FLLCM_C1_SEL_LO       4
`define FLLCM_C1_MONDIS       1
// ---------------------------------------------------------------
// Control 2 fields
// ---------------------------------------------------------------
`define FLLCM_C2_LOCK_LOSS_RESET_ENABLE        7
`define FLLCM_C2_MFD_HI       6
`define FLLCM_C2_MFD_LO       4
`define FLLCM_C2_CLOCK_LOSS_RESET_ENABLE        3
`define FLLCM_C2_RFD_HI       2
`define FLLCM_C2_RFD_LO       0
// ---------------------------------------------------------------
// Status 1 fields
// ---------------------------------------------------------------
`define FLLCM_S1_IF           0
`define FLLCM_S1_EXT_REFERENCE_STATUS         1
`define FLLCM_S1_CLOCK_LOST_FLAG         2
`define FLLCM_S1_LOCK         3
`define FLLCM_S1_LOCK_LOST_FLAG         4
// ---------------------------------------------------------------
// Reset values and mode codes (clock-select encoding)
// ---------------------------------------------------------------
`define FLLCM_C1_RESET        8'h00
`define FLLCM_C2_RESET        8'h30
`define FLLCM_MODE_SCM        2'h0
`define FLLCM_MODE_FEI        2'h1
`define FLLCM_MODE_FBE        2'h2
`define FLLCM_MODE_FEE        2'h3
// ---------------------------------------------------------------
// Timing counts (lock/unlock error windows in oscillator edges / timeouts in system cycles)
// ---------------------------------------------------------------
`define FLLCM_LOCK_WIN        8'h02
`define FLLCM_UNLOCK_WIN      8'h04
`define FLLCM_REF_TIMEOUT     8'hFF
`define FLLCM_OSC_TIMEOUT     8'h10
`endif

// >>> core/fllcm_monitor.v
// Frequency-locked-loop lock and clock-loss monitor with mode switching
// Function
// - Count oscillator edges per reference period, subtract multiply factor into signed error.
// - Lock bit sets only when error sits inside the lock window.
// - Lock bit clears when off, self-clocked, or loop bypassed.
// - Error leaving unlock window after lock sets sticky lock-lost flag.
// - Expected unlock conditions never set the lock-lost flag.
// - Lock loss gives system reset if its enable set, else interrupt.
// - Status read then writing one to interrupt flag clears lost flags.
// - Oscillator-stable sets when error steady over two samples and oscillator toggles.
// - Oscillator-stable clears when generator is off.
// - External-reference status shows reference meets minimum frequency.
// - Bypassed-external loses reference: go self-clocked, hold frequency.
// - Engaged-external loses reference: go self-clocked, hold frequencies.
// - Engaged-external unlocked loses reference: output frequency doubles.
// - Engaged-external loses oscillator: go bypassed-external, output is reference over divider.
// - Engaged-internal loses oscillator: go self-clocked, hold frequencies.
// - Self-clocked is reset mode and ignores the reference.
// - Automatic switch updates both clock-select and clock-status fields.
// - Clock loss sets clock-lost flag, reset if enabled, else interrupt.
// - Engaged clock loss also loses lock; lock reset overrides clock interrupt.
// - Monitor disable bit turns off clock-loss monitoring.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "fllcm_defines.vh"

module fllcm_monitor #(
   parameter CNT_W = 8
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [1:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   input  wire             external_reference_clock,
   input  wire             oscillator_output_clock,
   input  wire             gen_off,
   output wire             irq,
   output reg              sys_reset_req,
   output wire [1:0]       clock_mode_status,
   output wire             hold_freq,
   output wire             double_freq,
   output wire [2:0]       out_divider
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ---------------------------------------------------------------
   reg  [2:0]       ref_sync_ff;
   reg  [2:0]       osc_sync_ff;
   wire             ref_edge;
   wire             osc_edge;

   // Two stages before use, third stage only for edge detection
   always @(posedge clk) begin
      if (rst) begin
         ref_sync_ff <= 3'h0;
         osc_sync_ff <= 3'h0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[1:0], external_reference_clock};
         osc_sync_ff <= {osc_sync_ff[1:0], oscillator_output_clock};
      end
   end
   assign ref_edge = ref_sync_ff[1] & ~ref_sync_ff[2];
   assign osc_edge = osc_sync_ff[1] & ~osc_sync_ff[2];

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg  [7:0]       ctrl1_ff;
   reg  [7:0]       ctrl2_ff;
   reg  [1:0]       mode_ff;
   reg              lock_ff;
   reg              lock_lost_flag_ff;
   reg              clock_lost_flag_ff;
   reg              if_ff;
   reg              ext_reference_status_ff;
   reg              oscillator_stable_ff;
   reg              unlocked_loss_ff;
   reg              stat_read_ff;
   reg  [CNT_W-1:0] osc_cnt_ff;
   reg  signed [CNT_W:0] err_ff;
   reg  signed [CNT_W:0] prev_err_ff;
   reg  [1:0]       steady_ff;
   reg  [7:0]       ref_tmo_ff;
   reg  [7:0]       osc_tmo_ff;

   wire [1:0]       sel_field;
   wire             mon_dis;
   wire             lock_loss_reset_enable;
   wire             clock_loss_reset_enable;
   wire [CNT_W-1:0] mult;
   wire             uses_ref;
   wire             uses_osc;
   wire             engaged;

   assign sel_field = ctrl1_ff[`FLLCM_C1_SEL_HI:`FLLCM_C1_SEL_LO];
   assign mon_dis   = ctrl1_ff[`FLLCM_C1_MONDIS];
   assign lock_loss_reset_enable     = ctrl2_ff[`FLLCM_C2_LOCK_LOSS_RESET_ENABLE];
   assign clock_loss_reset_enable     = ctrl2_ff[`FLLCM_C2_CLOCK_LOSS_RESET_ENABLE];
   // Multiply factor scaled so small factors still give useful counts
   assign mult      = {{(CNT_W-5){1'b0}},
                       ctrl2_ff[`FLLCM_C2_MFD_HI:`FLLCM_C2_MFD_LO], 2'h0};
   assign uses_ref  = (mode_ff == `FLLCM_MODE_FEE) | (mode_ff == `FLLCM_MODE_FBE);
   assign uses_osc  = (mode_ff == `FLLCM_MODE_FEE) | (mode_ff == `FLLCM_MODE_FEI);
   assign engaged   = uses_osc;

   // Signed magnitude test used by lock, unlock and stability checks
   function in_window;
      input signed [CNT_W:0] val;
      input [7:0]            lim;
      reg   signed [CNT_W:0] slim;
      begin
         slim = $signed({{(CNT_W-7){1'b0}}, lim});
         in_window = (val <= slim) && (val >= -slim);
      end
   endfunction

   // ---------------------------------------------------------------
   // Count error per reference period
   // ---------------------------------------------------------------
   wire signed [CNT_W:0] cur_err;
   wire signed [CNT_W:0] err_delta;
   assign cur_err   = $signed({1'b0, osc_cnt_ff}) - $signed({1'b0, mult});
   assign err_delta = cur_err - err_ff;

   always @(posedge clk) begin
      if (rst) begin
         osc_cnt_ff  <= {CNT_W{1'b0}};
         err_ff      <= {(CNT_W+1){1'b0}};
         prev_err_ff <= {(CNT_W+1){1'b0}};
      end else if (ref_edge) begin
         // sample error at each reference edge
         osc_cnt_ff  <= {{(CNT_W-1){1'b0}}, osc_edge};
         err_ff      <= cur_err;
         prev_err_ff <= err_ff;
      end else if (osc_edge && (osc_cnt_ff != {CNT_W{1'b1}})) begin
         osc_cnt_ff  <= osc_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // Clock-loss timers
   // ---------------------------------------------------------------
   wire ref_lost;
   wire osc_lost;
   // Timeouts measured in system cycles; a stuck pin saturates its timer
   always @(posedge clk) begin
      if (rst) begin
         ref_tmo_ff <= 8'h00;
         osc_tmo_ff <= 8'h00;
      end else begin
         ref_tmo_ff <= ref_edge ? 8'h00 :
                       (ref_tmo_ff == `FLLCM_REF_TIMEOUT) ? ref_tmo_ff : ref_tmo_ff + 8'h01;
         osc_tmo_ff <= osc_edge ? 8'h00 :
                       (osc_tmo_ff == `FLLCM_OSC_TIMEOUT) ? osc_tmo_ff : osc_tmo_ff + 8'h01;
      end
   end
   assign ref_lost = (ref_tmo_ff == `FLLCM_REF_TIMEOUT);
   assign osc_lost = (osc_tmo_ff == `FLLCM_OSC_TIMEOUT);

   // ---------------------------------------------------------------
   // Loss events
   // ---------------------------------------------------------------
   wire expected_unlock;
   wire ext_loss_ev;
   wire osc_loss_ev;
   wire clk_loss_ev;
   wire lock_loss_ev;
   wire lock_ok;
   wire unlock_out;

   // off, self-clocked and bypassed are expected unlocks
   assign expected_unlock = gen_off | ~engaged;
   assign ext_loss_ev  = ~mon_dis & ~gen_off & uses_ref & ref_lost;
   assign osc_loss_ev  = ~mon_dis & ~gen_off & uses_osc & osc_lost;
   assign clk_loss_ev  = ext_loss_ev | osc_loss_ev;
   assign lock_ok      = in_window(err_ff, `FLLCM_LOCK_WIN);
   assign unlock_out   = ~in_window(err_ff, `FLLCM_UNLOCK_WIN);
   // only unexpected loss counts; engaged clock loss also drops lock
   assign lock_loss_ev = lock_ff & ~expected_unlock & (unlock_out | clk_loss_ev);

   // ---------------------------------------------------------------
   // Mode control and register writes
   // ---------------------------------------------------------------
   reg [1:0] nxt_mode;
   reg       nxt_unl;
   always @* begin
      nxt_mode = mode_ff;
      nxt_unl  = unlocked_loss_ff;
      if (reg_wr && (reg_addr == `FLLCM_ADDR_CTRL1)) begin
         nxt_mode = reg_wdata[`FLLCM_C1_SEL_HI:`FLLCM_C1_SEL_LO];
         nxt_unl  = 1'b0;
      end
      if (ext_loss_ev) begin
         nxt_mode = `FLLCM_MODE_SCM;
         nxt_unl  = (mode_ff == `FLLCM_MODE_FEE) & ~lock_ff;
      end else if (osc_loss_ev) begin
         // engaged-external to bypassed-external; engaged-internal to self
         nxt_mode = (mode_ff == `FLLCM_MODE_FEE) ? `FLLCM_MODE_FBE : `FLLCM_MODE_SCM;
         nxt_unl  = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         ctrl1_ff         <= `FLLCM_C1_RESET;
         ctrl2_ff         <= `FLLCM_C2_RESET;
         mode_ff          <= `FLLCM_MODE_SCM;
         unlocked_loss_ff <= 1'b0;
      end else begin
         mode_ff          <= nxt_mode;
         unlocked_loss_ff <= nxt_unl;
         if (reg_wr && (reg_addr == `FLLCM_ADDR_CTRL2))
            ctrl2_ff <= reg_wdata;
         // automatic switch rewrites the select field
         if (clk_loss_ev)
            ctrl1_ff <= {ctrl1_ff[7:6], nxt_mode, ctrl1_ff[3:0]};
         else if (reg_wr && (reg_addr == `FLLCM_ADDR_CTRL1))
            ctrl1_ff <= {reg_wdata[7:1], 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   wire clr_seq;
   // status read must precede the write of one to the interrupt flag
   assign clr_seq = stat_read_ff & reg_wr & (reg_addr == `FLLCM_ADDR_STAT1) &
                    reg_wdata[`FLLCM_S1_IF];

   always @(posedge clk) begin
      if (rst) begin
         lock_ff       <= 1'b0;
         lock_lost_flag_ff       <= 1'b0;
         clock_lost_flag_ff       <= 1'b0;
         if_ff         <= 1'b0;
         ext_reference_status_ff       <= 1'b0;
         oscillator_stable_ff       <= 1'b0;
         steady_ff     <= 2'h0;
         stat_read_ff  <= 1'b0;
         sys_reset_req <= 1'b0;
      end else begin
         if (reg_rd && (reg_addr == `FLLCM_ADDR_STAT1))
            stat_read_ff <= 1'b1;
         else if (reg_wr && (reg_addr == `FLLCM_ADDR_STAT1))
            stat_read_ff <= 1'b0;
         // expected unlock clears lock; lock needs lock window
         if (expected_unlock || lock_loss_ev)
            lock_ff <= 1'b0;
         else if (ref_edge && lock_ok && !lock_ff)
            lock_ff <= 1'b1;
         // sticky lock-lost, set wins over clear
         if (lock_loss_ev)
            lock_lost_flag_ff <= 1'b1;
         else if (clr_seq)
            lock_lost_flag_ff <= 1'b0;
         if (clk_loss_ev)
            clock_lost_flag_ff <= 1'b1;
         else if (clr_seq)
            clock_lost_flag_ff <= 1'b0;
         // interrupt flag on events not turned into reset; lock reset wins
         if ((lock_loss_ev && !lock_loss_reset_enable) || (clk_loss_ev && !clock_loss_reset_enable && !(lock_loss_ev && lock_loss_reset_enable)))
            if_ff <= 1'b1;
         else if (clr_seq)
            if_ff <= 1'b0;
         sys_reset_req <= (lock_loss_ev & lock_loss_reset_enable) | (clk_loss_ev & clock_loss_reset_enable);
         ext_reference_status_ff <= ~ref_lost;
         // two consecutive steady samples with a toggling oscillator
         if (ref_edge)
            steady_ff <= in_window(err_delta, `FLLCM_UNLOCK_WIN) ?
                         {steady_ff[0], 1'b1} : 2'h0;
         if (gen_off)
            oscillator_stable_ff <= 1'b0;
         else
            oscillator_stable_ff <= (&steady_ff) & ~osc_lost;
      end
   end

   // ---------------------------------------------------------------
   // Read port, data in the cycle after the strobe
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `FLLCM_ADDR_CTRL1)
            reg_rdata <= ctrl1_ff;
         else if (reg_addr == `FLLCM_ADDR_CTRL2)
            reg_rdata <= ctrl2_ff;
         else if (reg_addr == `FLLCM_ADDR_STAT1)
            reg_rdata <= {mode_ff, 1'b0, lock_lost_flag_ff, lock_ff, clock_lost_flag_ff, ext_reference_status_ff, if_ff};
         else
            reg_rdata <= {7'h00, oscillator_stable_ff};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Outputs toward clock tree
   // ---------------------------------------------------------------
   // status field follows the live mode
   assign clock_mode_status = mode_ff;
   assign irq               = if_ff;
   // held frequency after a clock loss into self-clocked, except an unlocked engaged-external one
   assign hold_freq         = (mode_ff == `FLLCM_MODE_SCM) & clock_lost_flag_ff & ~unlocked_loss_ff;
   assign double_freq       = unlocked_loss_ff;
   // bypassed output is reference over divider
   assign out_divider       = ctrl2_ff[`FLLCM_C2_RFD_HI:`FLLCM_C2_RFD_LO];

endmodule // fllcm_monitor

// >>> bench/fllcm_assertions.sv
// Port-level concurrent checks for the clock-loss monitor
`timescale 1ns/1ps
module fllcm_assertions #(
   parameter CNT_W = 8
) (
   input wire       clk,
   input wire       rst,
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       external_reference_clock,
   input wire       oscillator_output_clock,
   input wire       gen_off,
   input wire       irq,
   input wire       sys_reset_req,
   input wire [1:0] clock_mode_status,
   input wire       hold_freq,
   input wire       double_freq,
   input wire [2:0] out_divider
);
   // ------------------------------------------------------------
   // Helpers and sequences
   // ------------------------------------------------------------
   // Software mode writes are told apart from automatic switches
   wire       c1_wr = reg_wr && (reg_addr == 2'h0);
   wire [2:0] wdiv  = reg_wdata[2:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence auto_sw_s;
      $changed(clock_mode_status) && !$past(c1_wr) && !$past(c1_wr, 2);
   endsequence
   sequence stat_rd_s;
      reg_rd && (reg_addr == 2'h2);
   endsequence
   sequence clr_wr_s;
      reg_wr && (reg_addr == 2'h2) && reg_wdata[0];
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   reset_mode_a: assert property ($fell(rst) |-> clock_mode_status == 2'h0)
      else $error("mode not self-clocked after reset");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   div_follow_a: assert property ((reg_wr && reg_addr == 2'h1) |=> out_divider == $past(wdiv))
      else $error("divider output does not follow control 2");
   stat_mode_a: assert property (stat_rd_s |=> reg_rdata[7:6] == $past(clock_mode_status))
      else $error("status mode field differs from mode output");
   stat_irq_a: assert property (stat_rd_s |=> reg_rdata[0] == $past(irq))
      else $error("interrupt flag bit differs from irq");
   stat2_zero_a: assert property ((reg_rd && reg_addr == 2'h3) |=> reg_rdata[7:1] == 7'h00)
      else $error("status 2 upper bits not zero");
   auto_path_a: assert property (auto_sw_s |->
      ($past(clock_mode_status) == 2'h3 && clock_mode_status != 2'h1) ||
      ($past(clock_mode_status) != 2'h0 && clock_mode_status == 2'h0))
      else $error("illegal automatic mode switch");
   switch_flag_a: assert property (auto_sw_s |-> ##[0:3] (irq || sys_reset_req))
      else $error("clock loss switch without interrupt or reset");
   flag_clear_a: assert property (stat_rd_s ##[1:2] clr_wr_s |=> !irq)
      else $error("flags not cleared by read then write sequence");
endmodule // fllcm_assertions

bind fllcm_monitor fllcm_assertions #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .external_reference_clock(external_reference_clock),
   .oscillator_output_clock(oscillator_output_clock), .gen_off(gen_off), .irq(irq),
   .sys_reset_req(sys_reset_req), .clock_mode_status(clock_mode_status),
   .hold_freq(hold_freq), .double_freq(double_freq), .out_divider(out_divider));

// >>> bench/fllcm_clk_src.sv
// Behavioural reference and oscillator clock sources facing the monitor
`timescale 1ns/1ps
module fllcm_clk_src (
   input  wire logic       ref_run,
   input  wire logic       osc_run,
   input  wire logic [7:0] osc_half,
   output logic            external_reference_clock,
   output logic            oscillator_output_clock
);
   // Reference well above minimum rate; a lost clock simply stands still
   initial begin
      external_reference_clock = 1'b0;
      forever begin
         #960;
         if (ref_run) external_reference_clock = ~external_reference_clock;
      end
   end
   // Offset start keeps oscillator phase unrelated to reference and system clock
   initial begin
      oscillator_output_clock = 1'b0;
      #7;
      forever begin
         #(osc_half);
         if (osc_run) oscillator_output_clock = ~oscillator_output_clock;
      end
   end
endmodule // fllcm_clk_src

// >>> bench/tb_fll_clock_loss_monitor.sv
// Self-checking bench for the clock-loss monitor
`timescale 1ns/1ps
`include "fllcm_defines.vh"
module tb_fll_clock_loss_monitor;
   logic        clk, rst, reg_wr, reg_rd, gen_off, ref_run, osc_run;
   logic [1:0]  reg_addr, clock_mode_status;
   logic [7:0]  reg_wdata, reg_rdata, osc_half, d;
   logic        ext_clk, osc_clk, irq, sys_reset_req, hold_freq, double_freq;
   logic [2:0]  out_divider;
   int          n_mismatch = 0, num_checks = 0, i, k;
   // Rows: address, write data, read mask, expected read
   logic [25:0] rows [5] = '{{2'h1, 8'h35, 8'hFF, 8'h35}, {2'h1, 8'h32, 8'hFF, 8'h32},
      {2'h0, 8'h03, 8'h33, 8'h02}, {2'h0, 8'h00, 8'h33, 8'h00}, {2'h3, 8'hFF, 8'hFE, 8'h00}};
   logic [7:0]  rst_cfg [2] = '{8'h3A, 8'hB2};
   fllcm_monitor dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_reference_clock(ext_clk),
      .oscillator_output_clock(osc_clk), .gen_off(gen_off), .irq(irq),
      .sys_reset_req(sys_reset_req), .clock_mode_status(clock_mode_status),
      .hold_freq(hold_freq), .double_freq(double_freq), .out_divider(out_divider));
   fllcm_clk_src u_src (.ref_run(ref_run), .osc_run(osc_run), .osc_half(osc_half),
      .external_reference_clock(ext_clk), .oscillator_output_clock(osc_clk));
   // ------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Whole run needs about 4k cycles; a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      give_verdict;
   end
   task give_verdict;
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read answer stands only in the cycle after the strobe
   task rd(input logic [1:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task poll(input logic [1:0] a, input int b, input logic v);
      for (k = 0; k < 300; k++) begin
         rd(a);
         if (d[b] === v) break;
      end
      chk({7'h00, d[b]}, {7'h00, v});
   endtask
   task wait_mode(input logic [1:0] m);
      for (k = 0; k < 3000 && clock_mode_status !== m; k++) @(negedge clk);
      chk({6'h00, clock_mode_status}, {6'h00, m});
   endtask
   // Flags update on the write edge itself, so look half a cycle later
   task clr;
      rd(2'h2);
      wr(2'h2, 8'h01);
      @(negedge clk);
   endtask
   // A restarted clock needs one rising edge to clear its saturated loss timer
   task settle;
      repeat (200) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, gen_off, reg_addr, reg_wdata} = '0;
      {ref_run, osc_run} = 2'b11;
      osc_half = 8'h50;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(2'h0);
      chk(d, `FLLCM_C1_RESET);
      rd(2'h1);
      chk(d, `FLLCM_C2_RESET);
      chk({6'h00, clock_mode_status}, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr(rows[i][25:24], rows[i][23:16]);
         rd(rows[i][25:24]);
         chk(d & rows[i][15:8], rows[i][7:0]);
      end
      $display("register rows done");
      wr(2'h0, 8'h30);
      wait_mode(2'h3);
      poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
      chk({7'h00, d[`FLLCM_S1_EXT_REFERENCE_STATUS]}, 8'h01);
      poll(2'h3, 0, 1'b1);
      osc_run <= 1'b0;
      wait_mode(2'h2);
      chk({5'h00, out_divider}, 8'h02);
      rd(2'h0);
      chk({6'h00, d[5:4]}, 8'h02);
      rd(2'h2);
      chk({6'h00, d[`FLLCM_S1_CLOCK_LOST_FLAG], d[`FLLCM_S1_LOCK]}, 8'h02);
      chk({7'h00, irq}, 8'h01);
      clr;
      chk({7'h00, irq}, 8'h00);
      ref_run <= 1'b0;
      wait_mode(2'h0);
      chk({7'h00, hold_freq}, 8'h01);
      clr;
      {ref_run, osc_run} <= 2'b11;
      settle;
      $display("oscillator and reference loss done");
      wr(2'h0, 8'h30);
      poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
      osc_half <= 8'h32;
      poll(2'h2, `FLLCM_S1_LOCK_LOST_FLAG, 1'b1);
      chk({7'h00, irq}, 8'h01);
      osc_half <= 8'h50;
      clr;
      chk({7'h00, irq}, 8'h00);
      poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
      gen_off <= 1'b1;
      poll(2'h2, `FLLCM_S1_LOCK, 1'b0);
      chk({7'h00, d[`FLLCM_S1_LOCK_LOST_FLAG]}, 8'h00);
      rd(2'h3);
      chk(d, 8'h00);
      gen_off <= 1'b0;
      poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
      ref_run <= 1'b0;
      wait_mode(2'h0);
      chk({6'h00, hold_freq, double_freq}, 8'h02);
      clr;
      ref_run <= 1'b1;
      settle;
      $display("lock loss and locked reference loss done");
      wr(2'h1, 8'h72);
      wr(2'h0, 8'h30);
      wait_mode(2'h3);
      ref_run <= 1'b0;
      wait_mode(2'h0);
      chk({7'h00, double_freq}, 8'h01);
      clr;
      ref_run <= 1'b1;
      wr(2'h1, 8'h32);
      wr(2'h0, 8'h10);
      wait_mode(2'h1);
      osc_run <= 1'b0;
      wait_mode(2'h0);
      clr;
      osc_run <= 1'b1;
      $display("unlocked reference and internal loss done");
      wr(2'h0, 8'h32);
      poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
      osc_run <= 1'b0;
      repeat (100) @(posedge clk);
      chk({6'h00, clock_mode_status}, 8'h03);
      rd(2'h2);
      chk({7'h00, d[`FLLCM_S1_CLOCK_LOST_FLAG]}, 8'h00);
      osc_run <= 1'b1;
      settle;
      $display("monitor disable done");
      for (i = 0; i < 2; i++) begin
         wr(2'h1, rst_cfg[i]);
         wr(2'h0, 8'h30);
         poll(2'h2, `FLLCM_S1_LOCK, 1'b1);
         osc_run <= 1'b0;
         for (k = 0; k < 3000 && sys_reset_req !== 1'b1; k++) @(negedge clk);
         chk({7'h00, sys_reset_req}, 8'h01);
         chk({7'h00, irq}, {7'h00, ~rst_cfg[i][7]});
         osc_run <= 1'b1;
         rst <= 1'b1;
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         @(negedge clk);
         chk({6'h00, clock_mode_status, irq}, 8'h00);
      end
      $display("reset on loss done");
      give_verdict;
   end
endmodule // tb_fll_clock_loss_monitor
